// ==== acr_regs.svh ====
// Register offsets, field positions, reset values and bus codes of the ACS/LTR register bank
`ifndef ACR_REGS_SVH
`define ACR_REGS_SVH

`define ACR_OFF_ACS_HDR 12'h220
`define ACR_OFF_ACS_CAPCTL 12'h224
`define ACR_OFF_EGRESS 12'h228
`define ACR_OFF_LTR_HDR 12'h230
`define ACR_OFF_SNOOP 12'h234
`define ACR_OFF_W 12

`define ACR_ACS_CAP_ID 16'h000D
`define ACR_LTR_CAP_ID 16'h0018
`define ACR_CAP_VER 4'h1
`define ACR_NEXT_PTR 12'h240

`define ACR_ACS_FEAT_N 7
`define ACR_ACS_CAP_BITS 7'h7F
`define ACR_EGR_SIZE_LSB 8
`define ACR_EGR_SIZE_W 8
`define ACR_EN_LSB 16
`define ACR_EN_RST 7'h00
`define ACR_EGR_MAX 8
`define ACR_EGR_RST 8'h00
`define ACR_EGRESS_FEAT 5

`define ACR_SNP_VAL_W 10
`define ACR_SNP_VAL_RST 10'h000
`define ACR_SNP_SCL_LSB 10
`define ACR_SNP_SCL_W 3
`define ACR_SNP_SCL_RST 3'h0

`define ACR_HTRANS_NONSEQ 2'h2
`define ACR_HSIZE_WORD 3'h2
`define ACR_HRESP_OKAY 1'h0
`define ACR_WORD_ZERO 32'h00000000

`endif

// ==== acr_pkg.sv ====
// Types shared by the ACS/LTR register bank
`default_nettype none
package acr_pkg;

   typedef enum logic [1:0] {
      ACR_PH_IDLE  = 2'b00,
      ACR_PH_WRITE = 2'b01,
      ACR_PH_READ  = 2'b10
   } acr_phase_t;

   typedef enum logic [2:0] {
      ACR_SEL_NONE       = 3'b000,
      ACR_SEL_ACS_HDR    = 3'b001,
      ACR_SEL_ACS_CAPCTL = 3'b010,
      ACR_SEL_EGRESS     = 3'b011,
      ACR_SEL_LTR_HDR    = 3'b100,
      ACR_SEL_SNOOP      = 3'b101
   } acr_sel_t;

endpackage
`default_nettype wire

// ==== acr_feature_gate.sv ====
// Registered gating of enable bits by capability bits and port role
`default_nettype none
module acr_feature_gate #(
   parameter int W = 7
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] cap_bits,
   input wire logic [W-1:0] enable_bits,
   input wire logic port_active,
   output logic [W-1:0] gated_ff
);

   if (W < 1) begin : g_w_check
      $error("acr_feature_gate: W must be at least 1");
   end

   // An enable without its capability, or on the wrong port role, leaves routing alone
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gated_ff <= '0;
      end else begin
         gated_ff <= port_active ? (cap_bits & enable_bits) : '0;
      end
   end

endmodule // acr_feature_gate
`default_nettype wire

// ==== acr_capability_regs.sv ====
// ACS and LTR extended capability registers of one switch port, AHB-Lite slave
//
// Added by the designer: the AHB-Lite register port.
`include "acr_regs.svh"
`default_nettype none
module acr_capability_regs
   import acr_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int EGR_W = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic port_downstream,
   output logic port_role_ff,
   output logic [`ACR_ACS_FEAT_N-1:0] acs_active_en,
   output logic [EGR_W-1:0] egress_block,
   output logic [`ACR_SNP_VAL_W-1:0] snoop_lat_value,
   output logic [`ACR_SNP_SCL_W-1:0] snoop_lat_scale
);

   // The size field reports EGR_W directly, so the vector may not outgrow eight ports
   if (ADDR_W < `ACR_OFF_W) begin : g_addr_w_check
      $error("acr_capability_regs: ADDR_W must be at least 12");
   end
   if (EGR_W < 1 || EGR_W > `ACR_EGR_MAX) begin : g_egr_w_check
      $error("acr_capability_regs: EGR_W must lie between 1 and 8");
   end

   localparam logic [`ACR_EGR_SIZE_W-1:0] EGR_SIZE = EGR_W[`ACR_EGR_SIZE_W-1:0];
   localparam logic [EGR_W-1:0] EGR_ALL = '1;
   localparam logic [`ACR_ACS_FEAT_N-1:0] ACS_CAP = `ACR_ACS_CAP_BITS;

   // Bus phase tracking
   acr_phase_t phase_ff;
   acr_phase_t nxt_phase;
   acr_sel_t sel_ff;
   acr_sel_t nxt_sel;
   logic hreadyout_ff;
   logic nxt_hreadyout;
   logic [31:0] hrdata_ff;
   logic hresp_ff;

   // Port role strap
   logic strap_taken_ff;

   // Stored fields
   logic [`ACR_ACS_FEAT_N-1:0] acs_en_ff;
   logic [EGR_W-1:0] egress_vec_ff;
   logic [`ACR_SNP_VAL_W-1:0] snoop_val_ff;
   logic [`ACR_SNP_SCL_W-1:0] snoop_scl_ff;

   logic addr_take;
   logic wr_commit;
   logic egress_active;
   logic [31:0] rd_word;
   logic [EGR_W-1:0] egress_gated_ff;

   // Write strobes and fixed read images
   logic rd_commit;
   logic wr_capctl;
   logic wr_egress;
   logic wr_snoop;
   logic [31:0] acs_hdr_word;
   logic [31:0] ltr_hdr_word;

   assign hrdata = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp = hresp_ff;

   // OKAY is the only answer; kept in a flop so every bus output launches from a register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp_ff <= `ACR_HRESP_OKAY;
      end else begin
         hresp_ff <= `ACR_HRESP_OKAY;
      end
   end

   // Role is sampled once after reset release so that a pin which settles late
   // during reset still defines which register set this port carries
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_taken_ff <= 1'b0;
      end else begin
         strap_taken_ff <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_role_ff <= 1'b0;
      end else if (!strap_taken_ff) begin
         port_role_ff <= port_downstream;
      end
   end

   // Address decode; registers of the other role answer as unmapped
   always_comb begin
      nxt_sel = ACR_SEL_NONE;
      case (haddr[`ACR_OFF_W-1:0])
         `ACR_OFF_ACS_HDR: begin
            if (port_role_ff) begin
               nxt_sel = ACR_SEL_ACS_HDR;
            end
         end
         `ACR_OFF_ACS_CAPCTL: begin
            if (port_role_ff) begin
               nxt_sel = ACR_SEL_ACS_CAPCTL;
            end
         end
         `ACR_OFF_EGRESS: begin
            if (port_role_ff) begin
               nxt_sel = ACR_SEL_EGRESS;
            end
         end
         `ACR_OFF_LTR_HDR: begin
            if (!port_role_ff) begin
               nxt_sel = ACR_SEL_LTR_HDR;
            end
         end
         `ACR_OFF_SNOOP: begin
            if (!port_role_ff) begin
               nxt_sel = ACR_SEL_SNOOP;
            end
         end
         default: begin
            nxt_sel = ACR_SEL_NONE;
         end
      endcase
      // Any address bit above the register window means a miss
      if (ADDR_W > `ACR_OFF_W) begin
         if ((haddr >> `ACR_OFF_W) != '0) begin
            nxt_sel = ACR_SEL_NONE;
         end
      end
   end

   // Only whole-word transfers reach the registers; narrower ones are ignored
   assign addr_take = hsel && hready && (htrans == `ACR_HTRANS_NONSEQ)
                      && (hsize == `ACR_HSIZE_WORD);

   // Reads take one wait state so that hrdata can come from a flip-flop
   always_comb begin
      nxt_phase = ACR_PH_IDLE;
      nxt_hreadyout = 1'b1;
      case (phase_ff)
         ACR_PH_READ: begin
            nxt_phase = ACR_PH_IDLE;
            nxt_hreadyout = 1'b1;
         end
         ACR_PH_IDLE, ACR_PH_WRITE: begin
            if (addr_take) begin
               nxt_phase = hwrite ? ACR_PH_WRITE : ACR_PH_READ;
               nxt_hreadyout = hwrite;
            end
         end
         default: begin
            nxt_phase = ACR_PH_IDLE;
            nxt_hreadyout = 1'b1;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_ff <= ACR_PH_IDLE;
      end else begin
         phase_ff <= nxt_phase;
      end
   end

   // Low only through the single read wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_ff <= 1'b1;
      end else begin
         hreadyout_ff <= nxt_hreadyout;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sel_ff <= ACR_SEL_NONE;
      end else if (addr_take) begin
         sel_ff <= nxt_sel;
      end
   end

   // Write data phase always completes with no wait, hreadyout is high there
   assign wr_commit = (phase_ff == ACR_PH_WRITE);
   assign rd_commit = (phase_ff == ACR_PH_READ);

   // One write strobe per writable word; the select is held through the data phase
   assign wr_capctl = wr_commit && (sel_ff == ACR_SEL_ACS_CAPCTL);
   assign wr_egress = wr_commit && (sel_ff == ACR_SEL_EGRESS);
   assign wr_snoop = wr_commit && (sel_ff == ACR_SEL_SNOOP);

   // Header images never change; only the port role decides whether they are seen
   assign acs_hdr_word = {`ACR_NEXT_PTR, `ACR_CAP_VER, `ACR_ACS_CAP_ID};
   assign ltr_hdr_word = {`ACR_NEXT_PTR, `ACR_CAP_VER, `ACR_LTR_CAP_ID};

   // Read word; everything not listed reads as zero
   always_comb begin
      rd_word = `ACR_WORD_ZERO;
      case (sel_ff)
         ACR_SEL_ACS_HDR: begin
            rd_word = acs_hdr_word;
         end
         ACR_SEL_ACS_CAPCTL: begin
            rd_word[`ACR_ACS_FEAT_N-1:0] = ACS_CAP;
            rd_word[`ACR_EGR_SIZE_LSB +: `ACR_EGR_SIZE_W] = EGR_SIZE;
            rd_word[`ACR_EN_LSB +: `ACR_ACS_FEAT_N] = acs_en_ff;
         end
         ACR_SEL_EGRESS: begin
            rd_word[EGR_W-1:0] = egress_vec_ff;
         end
         ACR_SEL_LTR_HDR: begin
            rd_word = ltr_hdr_word;
         end
         ACR_SEL_SNOOP: begin
            rd_word[`ACR_SNP_VAL_W-1:0] = snoop_val_ff;
            rd_word[`ACR_SNP_SCL_LSB +: `ACR_SNP_SCL_W] = snoop_scl_ff;
         end
         default: begin
            rd_word = `ACR_WORD_ZERO;
         end
      endcase
   end

   // Captured at the end of the wait state and held until the next read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= `ACR_WORD_ZERO;
      end else if (rd_commit) begin
         hrdata_ff <= rd_word;
      end
   end

   // Enables keep only bits 22:16; the headers take no write at all
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acs_en_ff <= `ACR_EN_RST;
      end else if (wr_capctl) begin
         acs_en_ff <= hwdata[`ACR_EN_LSB +: `ACR_ACS_FEAT_N];
      end
   end

   // Vector bits above EGR_W stay reserved: they read zero and drop writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         egress_vec_ff <= `ACR_EGR_RST;
      end else if (wr_egress) begin
         egress_vec_ff <= hwdata[EGR_W-1:0];
      end
   end

   // Value and scale land together from one word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         snoop_val_ff <= `ACR_SNP_VAL_RST;
      end else if (wr_snoop) begin
         snoop_val_ff <= hwdata[`ACR_SNP_VAL_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         snoop_scl_ff <= `ACR_SNP_SCL_RST;
      end else if (wr_snoop) begin
         snoop_scl_ff <= hwdata[`ACR_SNP_SCL_LSB +: `ACR_SNP_SCL_W];
      end
   end

   // Datapath controls, one cycle behind the registers
   acr_feature_gate #(
      .W(`ACR_ACS_FEAT_N)
   ) u_acs_gate (
      .hclk(hclk),
      .hresetn(hresetn),
      .cap_bits(ACS_CAP),
      .enable_bits(acs_en_ff),
      .port_active(port_role_ff),
      .gated_ff(acs_active_en)
   );

   // The vector only steers traffic while egress control is both offered and enabled
   assign egress_active = port_role_ff && acs_en_ff[`ACR_EGRESS_FEAT]
                          && ACS_CAP[`ACR_EGRESS_FEAT];

   acr_feature_gate #(
      .W(EGR_W)
   ) u_egress_gate (
      .hclk(hclk),
      .hresetn(hresetn),
      .cap_bits(EGR_ALL),
      .enable_bits(egress_vec_ff),
      .port_active(egress_active),
      .gated_ff(egress_gated_ff)
   );

   assign egress_block = egress_gated_ff;

   // Latency limits face the LTR logic only on the upstream port
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         snoop_lat_value <= `ACR_SNP_VAL_RST;
      end else begin
         snoop_lat_value <= port_role_ff ? `ACR_SNP_VAL_RST : snoop_val_ff;
      end
   end

   // Held at reset value on a downstream port so the LTR side never sees a stale limit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         snoop_lat_scale <= `ACR_SNP_SCL_RST;
      end else begin
         snoop_lat_scale <= port_role_ff ? `ACR_SNP_SCL_RST : snoop_scl_ff;
      end
   end

endmodule // acr_capability_regs
`default_nettype wire

// ==== acr_capability_regs_assertions.sv ====
// Port-level checks of the ACS/LTR register bank
`default_nettype none
module acr_regs_checker #(
   parameter int ADDR_W = 12,
   parameter int EGR_W = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic port_role_ff,
   input wire logic [6:0] acs_active_en,
   input wire logic [EGR_W-1:0] egress_block,
   input wire logic [9:0] snoop_lat_value,
   input wire logic [2:0] snoop_lat_scale
);
   timeunit 1ns;
   timeprecision 1ps;
   logic go;
   logic rd_go;
   assign go = hsel && hready && htrans == 2'h2 && hsize == 3'h2;
   assign rd_go = go && !hwrite;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_read_one_wait: assert property (rd_go |=> !hreadyout ##1 hreadyout)
      else $error("read wait not one cycle");
   a_write_no_wait: assert property (go && hwrite |=> hreadyout)
      else $error("write stalled");
   a_acs_header: assert property (
      rd_go && haddr == 12'h220 && port_role_ff |-> ##2 hrdata == 32'h2401000D)
      else $error("ACS header wrong");
   a_ltr_header: assert property (
      rd_go && haddr == 12'h230 && !port_role_ff |-> ##2 hrdata == 32'h24010018)
      else $error("LTR header wrong");
   a_capctl_fixed: assert property (
      rd_go && haddr == 12'h224 && port_role_ff
      |-> ##2 hrdata[15:0] == 16'h087F && hrdata[31:23] == 9'h000)
      else $error("capability bits wrong");
   a_role_hides: assert property (
      rd_go && (port_role_ff ? (haddr == 12'h230 || haddr == 12'h234)
      : (haddr >= 12'h220 && haddr <= 12'h228)) |-> ##2 hrdata == 32'h00000000)
      else $error("other role register visible");
   a_gate_role: assert property (!port_role_ff |-> acs_active_en == 7'h00 && egress_block == '0)
      else $error("upstream control active");
   a_egress_enabled: assert property (egress_block != '0 |-> acs_active_en[5])
      else $error("egress without enable");
   a_snoop_upstream: assert property (
      port_role_ff |-> snoop_lat_value == 10'h000 && snoop_lat_scale == 3'h0)
      else $error("snoop latency on downstream");
   a_reset_clear: assert property (
      $rose(hresetn) |-> acs_active_en == 7'h00
      && egress_block == '0 && snoop_lat_value == 10'h000)
      else $error("controls not cleared");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   c_down_read: cover property (rd_go && port_role_ff);
   c_egress: cover property (egress_block != '0);
   c_snoop: cover property (snoop_lat_value != 10'h000);
endmodule // acr_regs_checker
bind acr_capability_regs acr_regs_checker #(.ADDR_W(ADDR_W), .EGR_W(EGR_W)) acr_regs_checker_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .port_role_ff(port_role_ff), .acs_active_en(acs_active_en),
   .egress_block(egress_block), .snoop_lat_value(snoop_lat_value),
   .snoop_lat_scale(snoop_lat_scale));
`default_nettype wire

// ==== acr_tb.sv ====
// Self-checking bench of the ACS/LTR register bank
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h00000000;
   logic port_downstream = 1'b1;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic port_role_ff;
   logic [6:0] acs_active_en;
   logic [7:0] egress_block;
   logic [9:0] snoop_lat_value;
   logic [2:0] snoop_lat_scale;
   logic [31:0] rd;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   always #10 hclk = ~hclk;
   acr_capability_regs acr_capability_regs_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .port_downstream(port_downstream),
      .port_role_ff(port_role_ff), .acs_active_en(acs_active_en),
      .egress_block(egress_block), .snoop_lat_value(snoop_lat_value),
      .snoop_lat_scale(snoop_lat_scale));
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Holds each phase until hready is seen high, never assuming a latency
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h00000000);
      `CHK(rd, e);
   endtask
   task automatic do_reset(input logic down);
      hresetn <= 1'b0;
      hsel <= 1'b0;
      port_downstream <= down;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
   endtask
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         finish_test;
      end
   end
   initial begin
      do_reset(1'b1);
      `CHK(port_role_ff, 1'b1);
      rchk(12'h220, 32'h2401000D);
      rchk(12'h224, 32'h0000087F);
      rchk(12'h228, 32'h00000000);
      rchk(12'h230, 32'h00000000);
      rchk(12'h234, 32'h00000000);
      rchk(12'h22C, 32'h00000000);
      $display("test downstream reset done");
      for (int i = 0; i < 7; i++) begin
         xfer(1'b1, 12'h224, 32'h00010000 << i);
         rchk(12'h224, (32'h00010000 << i) | 32'h0000087F);
         repeat (2) @(posedge hclk);
         `CHK(acs_active_en, 7'h01 << i);
      end
      xfer(1'b1, 12'h224, 32'hFFFFFFFF);
      xfer(1'b1, 12'h228, 32'hFFFFFFFF);
      rchk(12'h224, 32'h007F087F);
      rchk(12'h228, 32'h000000FF);
      `CHK(egress_block, 8'hFF);
      xfer(1'b1, 12'h224, 32'h00000000);
      xfer(1'b1, 12'h234, 32'hFFFFFFFF);
      rchk(12'h228, 32'h000000FF);
      `CHK(egress_block, 8'h00);
      `CHK(snoop_lat_value, 10'h000);
      // A byte-sized write must leave the vector alone
      hsize <= 3'h0;
      xfer(1'b1, 12'h228, 32'h00000000);
      hsize <= 3'h2;
      rchk(12'h228, 32'h000000FF);
      $display("test downstream controls done");
      do_reset(1'b0);
      `CHK(port_role_ff, 1'b0);
      rchk(12'h230, 32'h24010018);
      rchk(12'h234, 32'h00000000);
      rchk(12'h220, 32'h00000000);
      xfer(1'b1, 12'h224, 32'hFFFFFFFF);
      rchk(12'h224, 32'h00000000);
      xfer(1'b1, 12'h234, 32'hFFFFFFFF);
      rchk(12'h234, 32'h00001FFF);
      xfer(1'b1, 12'h234, 32'h00000A55);
      rchk(12'h234, 32'h00000A55);
      `CHK(snoop_lat_value, 10'h255);
      `CHK(snoop_lat_scale, 3'h2);
      `CHK(acs_active_en, 7'h00);
      $display("test upstream done");
      finish_test;
   end
endmodule // testbench
`default_nettype wire
